// >>> pkg/stt_pkg.sv
package stt_pkg;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_INSN = 8'h04;
    localparam logic [7:0] ADDR_STR_PTR = 8'h08;
    localparam logic [7:0] ADDR_TBL_BASE = 8'h0C;
    localparam logic [7:0] ADDR_COUNT = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;

    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_ZERO_BIT = 1;
    localparam int ST_OVFL_BIT = 2;
    localparam int ST_SUSP_BIT = 3;
    localparam int ST_BADOP_BIT = 4;
    localparam int ST_RESULT_LSB = 8;

    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [15:0] RST_COUNT = 16'h0000;
    localparam logic [7:0] RST_BYTE = 8'h00;

    localparam logic [7:0] OP_HIGH = 8'hB8;
    localparam logic [3:0] NIB_DOWN_REP = 4'hE;
    localparam logic [3:0] NIB_UP_ONE = 4'h2;
    localparam logic [3:0] W2_HIGH = 4'h0;
    localparam logic [3:0] W2_LOW = 4'hE;
    localparam logic [3:0] FIELD_NONE = 4'h0;

    localparam logic [31:0] STEP_UP = 32'h0000_0001;
    localparam logic [31:0] STEP_DOWN = 32'hFFFF_FFFF;
    localparam logic [15:0] COUNT_ONE = 16'h0001;

    typedef enum logic [1:0] {
        STT_MODE_COMPACT = 2'h0,
        STT_MODE_SEGMENTED = 2'h1,
        STT_MODE_LINEAR = 2'h2,
        STT_MODE_RSVD = 2'h3
    } stt_mode_t;

    typedef enum logic [5:0] {
        S_IDLE = 6'h01,
        S_TGT_REQ = 6'h02,
        S_TGT_WAIT = 6'h04,
        S_TBL_REQ = 6'h08,
        S_TBL_WAIT = 6'h10,
        S_UPDATE = 6'h20
    } stt_state_t;

    typedef enum logic [1:0] {
        MP_IDLE = 2'h1,
        MP_WAIT = 2'h2
    } stt_mp_state_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } stt_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } stt_apb_rsp_t;

    typedef struct packed {
        logic req;
        logic [31:0] addr;
    } stt_mem_req_t;
endpackage

// >>> src/stt_addr_calc.sv
module stt_addr_calc (
    input wire stt_pkg::stt_mode_t mode_i,
    input wire logic [31:0] tbl_base_i,
    input wire logic [7:0] tgt_byte_i,
    input wire logic [31:0] ptr_i,
    input wire logic down_i,
    output logic [31:0] tbl_addr_o,
    output logic [31:0] next_ptr_o
);
    import stt_pkg::*;

    // pointer width per mode
    // only linear carries into the upper half; compact and segmented wrap in 16 bits
    function automatic logic [31:0] mode_add(input stt_mode_t mode, input logic [31:0] a,
                                             input logic [31:0] b);
        logic [31:0] sum;
        sum = a + b;
        if (mode == STT_MODE_LINEAR) begin
            return sum;
        end
        return {a[31:16], sum[15:0]};
    endfunction

    assign tbl_addr_o = mode_add(mode_i, tbl_base_i, {24'h000000, tgt_byte_i});
    assign next_ptr_o = mode_add(mode_i, ptr_i, down_i ? STEP_DOWN : STEP_UP);
endmodule // stt_addr_calc

// >>> src/stt_mem_port.sv
module stt_mem_port (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [31:0] addr_i,
    input wire logic mem_ack_i,
    input wire logic [7:0] mem_rdata_i,
    output stt_pkg::stt_mem_req_t mem_o,
    output logic done_o,
    output logic [7:0] data_o
);
    import stt_pkg::*;

    stt_mp_state_t state;
    stt_mp_state_t next_state;
    stt_mem_req_t next_mem;
    logic next_done;
    logic [7:0] next_data;

    always_comb begin
        next_state = state;
        next_mem = mem_o;
        next_done = 1'b0;
        next_data = data_o;
        case (state)
            MP_IDLE: begin
                if (start_i) begin
                    next_mem.req = 1'b1;
                    next_mem.addr = addr_i;
                    next_state = MP_WAIT;
                end
            end
            MP_WAIT: begin
                // request and address stay put until the memory answers
                if (mem_ack_i) begin
                    next_mem.req = 1'b0;
                    next_data = mem_rdata_i;
                    next_done = 1'b1;
                    next_state = MP_IDLE;
                end
            end
            default: begin
                next_state = MP_IDLE;
                next_mem.req = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= MP_IDLE;
            mem_o <= '0;
            done_o <= 1'b0;
            data_o <= RST_BYTE;
        end else begin
            state <= next_state;
            mem_o <= next_mem;
            done_o <= next_done;
            data_o <= next_data;
        end
    end
endmodule // stt_mem_port

// >>> src/stt_unit.sv
module stt_unit (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire stt_pkg::stt_apb_req_t apb_i,
    output stt_pkg::stt_apb_rsp_t apb_o,
    input wire logic irq_pending_i,
    input wire logic mem_ack_i,
    input wire logic [7:0] mem_rdata_i,
    output stt_pkg::stt_mem_req_t mem_o
);
    import stt_pkg::*;

    stt_state_t state;
    stt_state_t next_state;
    stt_mode_t mode;
    stt_mode_t next_mode;
    logic [31:0] insn;
    logic [31:0] next_insn;
    logic [31:0] str_ptr;
    logic [31:0] next_str_ptr;
    logic [31:0] tbl_base;
    logic [31:0] next_tbl_base;
    logic [15:0] count;
    logic [15:0] next_count;
    logic [7:0] result;
    logic [7:0] next_result;
    logic [7:0] tgt_byte;
    logic [7:0] next_tgt_byte;
    logic zero;
    logic next_zero;
    logic ovfl;
    logic next_ovfl;
    logic susp;
    logic next_susp;
    logic badop;
    logic next_badop;
    logic is_down;
    logic next_is_down;
    stt_apb_rsp_t next_apb;

    logic busy;
    logic wr_fire;
    logic start_req;
    logic dec_down;
    logic dec_up;
    logic [15:0] cnt_dec;
    logic cont;
    logic mp_start;
    logic [31:0] mp_addr;
    logic mp_done;
    logic [7:0] mp_data;
    logic [31:0] tbl_addr;
    logic [31:0] step_ptr;

    assign busy = (state != S_IDLE);
    assign wr_fire = apb_i.psel & apb_i.penable & apb_o.pready & apb_i.pwrite;
    assign start_req = wr_fire & (apb_i.paddr == ADDR_CTRL) & apb_i.pwdata[CTRL_START_BIT];

    assign dec_down = (insn[15:8] == OP_HIGH) && (insn[7:4] != FIELD_NONE)
        && (insn[3:0] == NIB_DOWN_REP) && (insn[31:28] == W2_HIGH)
        && (insn[23:20] != FIELD_NONE) && (insn[19:16] == W2_LOW);
    assign dec_up = (insn[15:8] == OP_HIGH) && (insn[7:4] != FIELD_NONE)
        && (insn[3:0] == NIB_UP_ONE);

    // 16-bit counter wrap
    // a count of zero decrements to FFFF, which is how 65536 bytes are covered
    assign cnt_dec = count - COUNT_ONE;
    assign cont = is_down && (mp_data == RST_BYTE) && (cnt_dec != RST_COUNT);

    assign mp_start = (state == S_TGT_REQ) || (state == S_TBL_REQ);
    assign mp_addr = (state == S_TBL_REQ) ? tbl_addr : str_ptr;

    stt_addr_calc u_addr (
        .mode_i(mode),
        .tbl_base_i(tbl_base),
        .tgt_byte_i(tgt_byte),
        .ptr_i(str_ptr),
        .down_i(is_down),
        .tbl_addr_o(tbl_addr),
        .next_ptr_o(step_ptr)
    );

    stt_mem_port u_mem (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(mp_start),
        .addr_i(mp_addr),
        .mem_ack_i(mem_ack_i),
        .mem_rdata_i(mem_rdata_i),
        .mem_o(mem_o),
        .done_o(mp_done),
        .data_o(mp_data)
    );

    always_comb begin
        next_state = state;
        next_mode = mode;
        next_insn = insn;
        next_str_ptr = str_ptr;
        next_tbl_base = tbl_base;
        next_count = count;
        next_result = result;
        next_tgt_byte = tgt_byte;
        next_zero = zero;
        next_ovfl = ovfl;
        next_susp = susp;
        next_badop = badop;
        next_is_down = is_down;
        // software may only load operands while the engine rests, so the
        // engine's own updates never collide with a bus write
        if (wr_fire && !busy) begin
            if (apb_i.paddr == ADDR_CTRL) begin
                next_mode = stt_mode_t'(apb_i.pwdata[CTRL_MODE_LSB +: 2]);
            end else if (apb_i.paddr == ADDR_INSN) begin
                next_insn = apb_i.pwdata;
            end else if (apb_i.paddr == ADDR_STR_PTR) begin
                next_str_ptr = apb_i.pwdata;
            end else if (apb_i.paddr == ADDR_TBL_BASE) begin
                next_tbl_base = apb_i.pwdata;
            end else if (apb_i.paddr == ADDR_COUNT) begin
                next_count = apb_i.pwdata[15:0];
            end
        end
        case (state)
            S_IDLE: begin
                if (start_req) begin
                    next_susp = 1'b0;
                    // mode and opcode are checked against values already held,
                    // so a start bit written with a new mode is checked against the old one but runs in the new one
                    if ((dec_down || dec_up) && (mode != STT_MODE_RSVD)) begin
                        next_badop = 1'b0;
                        next_is_down = dec_down;
                        next_state = S_TGT_REQ;
                    end else begin
                        next_badop = 1'b1;
                    end
                end
            end
            S_TGT_REQ: begin
                next_state = S_TGT_WAIT;
            end
            S_TGT_WAIT: begin
                if (mp_done) begin
                    next_tgt_byte = mp_data;
                    next_state = S_TBL_REQ;
                end
            end
            S_TBL_REQ: begin
                next_state = S_TBL_WAIT;
            end
            S_TBL_WAIT: begin
                if (mp_done) begin
                    next_state = S_UPDATE;
                end
            end
            S_UPDATE: begin
                next_result = mp_data;
                next_zero = (mp_data == RST_BYTE);
                next_ovfl = (cnt_dec == RST_COUNT);
                next_str_ptr = step_ptr;
                next_count = cnt_dec;
                if (cont && irq_pending_i) begin
                    next_susp = 1'b1;
                    next_state = S_IDLE;
                end else if (cont) begin
                    next_state = S_TGT_REQ;
                end else begin
                    next_state = S_IDLE;
                end
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
    end

    always_comb begin
        next_apb = apb_o;
        next_apb.pready = 1'b0;
        next_apb.pslverr = 1'b0;
        if (apb_i.psel && apb_i.penable && !apb_o.pready) begin
            next_apb.pready = 1'b1;
            next_apb.prdata = RST_WORD;
            if (apb_i.paddr == ADDR_CTRL) begin
                next_apb.prdata[CTRL_MODE_LSB +: 2] = mode;
            end else if (apb_i.paddr == ADDR_INSN) begin
                next_apb.prdata = insn;
            end else if (apb_i.paddr == ADDR_STR_PTR) begin
                next_apb.prdata = str_ptr;
            end else if (apb_i.paddr == ADDR_TBL_BASE) begin
                next_apb.prdata = tbl_base;
            end else if (apb_i.paddr == ADDR_COUNT) begin
                next_apb.prdata[15:0] = count;
            end else if (apb_i.paddr == ADDR_STATUS) begin
                next_apb.prdata[ST_BUSY_BIT] = busy;
                next_apb.prdata[ST_ZERO_BIT] = zero;
                next_apb.prdata[ST_OVFL_BIT] = ovfl;
                next_apb.prdata[ST_SUSP_BIT] = susp;
                next_apb.prdata[ST_BADOP_BIT] = badop;
                next_apb.prdata[ST_RESULT_LSB +: 8] = result;
            end else begin
                next_apb.pslverr = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= S_IDLE;
            mode <= STT_MODE_COMPACT;
            insn <= RST_WORD;
            str_ptr <= RST_WORD;
            tbl_base <= RST_WORD;
            count <= RST_COUNT;
            result <= RST_BYTE;
            tgt_byte <= RST_BYTE;
            zero <= 1'b0;
            ovfl <= 1'b0;
            susp <= 1'b0;
            badop <= 1'b0;
            is_down <= 1'b0;
            apb_o <= '0;
        end else begin
            state <= next_state;
            mode <= next_mode;
            insn <= next_insn;
            str_ptr <= next_str_ptr;
            tbl_base <= next_tbl_base;
            count <= next_count;
            result <= next_result;
            tgt_byte <= next_tgt_byte;
            zero <= next_zero;
            ovfl <= next_ovfl;
            susp <= next_susp;
            badop <= next_badop;
            is_down <= next_is_down;
            apb_o <= next_apb;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    tbl_base_hold_a: assert property (busy |=> $stable(tbl_base))
        else $error("table base changed while busy");
    zero_flag_a: assert property ((state == S_UPDATE) |=> (zero == (result == 8'h00)))
        else $error("zero flag does not follow result");
    ovfl_flag_a: assert property ((state == S_UPDATE) |=> (ovfl == (count == 16'h0000)))
        else $error("overflow flag does not follow counter");
    result_load_a: assert property ((state == S_UPDATE) |=> (result == $past(mp_data)))
        else $error("result byte not loaded from table");
    cnt_step_a: assert property ((state == S_UPDATE) |=> (count == $past(count) - 16'h0001))
        else $error("counter not decremented by one");
    ptr_down_a: assert property ((state == S_UPDATE) && is_down && (mode == STT_MODE_LINEAR)
        |=> (str_ptr == $past(str_ptr) - 32'h0000_0001))
        else $error("pointer not decremented");
    ptr_up_lin_a: assert property ((state == S_UPDATE) && !is_down && (mode == STT_MODE_LINEAR)
        |=> (str_ptr == $past(str_ptr) + 32'h0000_0001) && (state == S_IDLE))
        else $error("single step did not advance and stop");
    ptr_compact_a: assert property ((state == S_UPDATE) && (mode == STT_MODE_COMPACT)
        |=> (str_ptr[31:16] == $past(str_ptr[31:16])))
        else $error("compact pointer touched upper half");
    repeat_stop_a: assert property ((state == S_UPDATE) && is_down
        && ((mp_data != 8'h00) || (count == 16'h0001)) |=> (state == S_IDLE) && !susp)
        else $error("repeat did not stop");
    repeat_go_a: assert property ((state == S_UPDATE) && cont && !irq_pending_i
        |=> (state == S_TGT_REQ) ##1 (state == S_TGT_WAIT))
        else $error("repeat did not continue");
    pause_a: assert property ((state == S_UPDATE) && cont && irq_pending_i
        |=> (state == S_IDLE) && susp)
        else $error("pending interrupt not honoured between steps");
    tbl_addr_a: assert property ((state == S_TBL_REQ) && (mode == STT_MODE_LINEAR)
        |=> mem_o.req && (mem_o.addr == tbl_base + {24'h000000, tgt_byte}))
        else $error("table address wrong");
    step_order_a: assert property ((state == S_TBL_WAIT) && mp_done
        |=> (state == S_UPDATE) && $stable(str_ptr) && $stable(count))
        else $error("pointer moved before result load");
    apb_ready_a: assert property (apb_i.psel && apb_i.penable && !apb_o.pready
        |=> apb_o.pready ##1 !apb_o.pready)
        else $error("apb answer not one cycle after access");
    tgt_addr_a: assert property ((state == S_TGT_REQ)
        |=> mem_o.req && (mem_o.addr == str_ptr))
        else $error("string byte address wrong");
    // compact and segmented tables wrap inside the base's 64K page
    tbl_addr_wrap_a: assert property ((state == S_TBL_REQ) && (mode != STT_MODE_LINEAR)
        |=> mem_o.req && (mem_o.addr == {tbl_base[31:16], tbl_base[15:0] + {8'h00, tgt_byte}}))
        else $error("wrapped table address wrong");
    mem_hold_a: assert property (mem_o.req && !mem_ack_i
        |=> mem_o.req && $stable(mem_o.addr))
        else $error("memory request dropped before answer");
    ptr_low_down_a: assert property ((state == S_UPDATE) && is_down
        |=> (str_ptr[15:0] == $past(str_ptr[15:0]) - 16'h0001))
        else $error("pointer low half not decremented");
    ptr_seg_a: assert property ((state == S_UPDATE) && (mode == STT_MODE_SEGMENTED)
        |=> (str_ptr[31:16] == $past(str_ptr[31:16])))
        else $error("segmented pointer touched upper half");
    single_stop_a: assert property ((state == S_UPDATE) && !is_down
        |=> (state == S_IDLE) && (count == $past(count) - 16'h0001))
        else $error("single step repeated or miscounted");
    // a refused start must leave the engine at rest with the flag raised
    badop_set_a: assert property (start_req && !busy
        && !((dec_down || dec_up) && (mode != STT_MODE_RSVD)) |=> badop && (state == S_IDLE))
        else $error("bad opcode not refused");

    repeat_run_c: cover property ((state == S_UPDATE) && cont ##[1:40] (state == S_UPDATE) && !cont);
    single_run_c: cover property ((state == S_UPDATE) && !is_down);
    pause_c: cover property ((state == S_UPDATE) && cont && irq_pending_i);
    badop_c: cover property (start_req && !busy && !dec_down && !dec_up);
    linear_down_c: cover property ((state == S_UPDATE) && is_down && (mode == STT_MODE_LINEAR));
endmodule // stt_unit

// >>> tb/string_translate_test_unit_tb.sv
module string_translate_test_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import stt_pkg::*;

    localparam logic [31:0] INSN_DN = 32'h0C9E_B86E;
    localparam logic [31:0] BAD [7] = '{32'h0C9E_B80E, 32'h0C0E_B86E, 32'h1C9E_B86E,
        32'h0C9F_B86E, 32'h0C9E_B86A, 32'h0C9E_B96E, 32'h0000_B802};
    localparam logic [31:0] PTR [3] = '{32'h0000_FFFF, 32'h0003_FFFF, 32'h0003_FFFF};
    localparam logic [31:0] NPTR [3] = '{32'h0000_0000, 32'h0003_0000, 32'h0004_0000};
    localparam logic [31:0] BASE [3] = '{32'h0000_FFF0, 32'h0005_FFF0, 32'h0005_FFF0};
    localparam logic [31:0] TADR [3] = '{32'h0000_0010, 32'h0005_0010, 32'h0006_00EF};
    localparam logic [7:0] TGT [3] = '{8'h20, 8'h20, 8'hFF};

    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    stt_apb_req_t apb = '0;
    stt_apb_rsp_t apb_rsp;
    logic irq_pending = 1'b0;
    logic mem_ack;
    logic [7:0] mem_rdata;
    stt_mem_req_t mem_req;
    int n_mismatch = 0;
    int num_checks = 0;
    logic [31:0] rd;
    logic err;

    always #5 clk_i = ~clk_i;

    stt_unit u_dut (.clk_i(clk_i), .rst_i(rst_i), .apb_i(apb), .apb_o(apb_rsp),
        .irq_pending_i(irq_pending), .mem_ack_i(mem_ack), .mem_rdata_i(mem_rdata),
        .mem_o(mem_req));
    stt_mem_model u_mem (.clk_i(clk_i), .rst_i(rst_i), .mem_i(mem_req),
        .mem_ack_o(mem_ack), .mem_rdata_o(mem_rdata));

    task results;
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int i;
        @(posedge clk_i);
        apb.psel <= 1'b1;
        apb.penable <= 1'b0;
        apb.pwrite <= wr;
        apb.paddr <= a;
        apb.pwdata <= wd;
        @(posedge clk_i);
        apb.penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_i);
            if (apb_rsp.pready === 1'b1) break;
        end
        if (i == 20) begin
            n_mismatch++;
            results();
        end
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb.psel <= 1'b0;
        apb.penable <= 1'b0;
    endtask

    task go(input logic [1:0] m);
        xfer(1'b1, ADDR_CTRL, (32'(m) << CTRL_MODE_LSB) | (32'h1 << CTRL_START_BIT));
    endtask

    // mode goes in first: the start check uses the mode held before the start write
    task load(input logic [1:0] m, input logic [31:0] insn, p, b, input logic [15:0] c);
        xfer(1'b1, ADDR_CTRL, 32'(m) << CTRL_MODE_LSB);
        xfer(1'b1, ADDR_INSN, insn);
        xfer(1'b1, ADDR_STR_PTR, p);
        xfer(1'b1, ADDR_TBL_BASE, b);
        xfer(1'b1, ADDR_COUNT, {16'h0000, c});
    endtask

    task wait_idle;
        int k;
        for (k = 0; k < 300; k++) begin
            xfer(1'b0, ADDR_STATUS, 32'h0);
            if (rd[ST_BUSY_BIT] === 1'b0) break;
        end
        if (k == 300) begin
            n_mismatch++;
            results();
        end
    endtask

    function automatic logic [31:0] stat(logic [7:0] res, logic susp, logic v, logic z);
        logic [31:0] s;
        s = 32'h0;
        s[ST_RESULT_LSB +: 8] = res;
        s[ST_SUSP_BIT] = susp;
        s[ST_OVFL_BIT] = v;
        s[ST_ZERO_BIT] = z;
        return s;
    endfunction

    task expect_end(input logic [31:0] p, input logic [15:0] c, input logic [31:0] st, msk);
        xfer(1'b0, ADDR_STR_PTR, 32'h0);
        chk(rd, p);
        xfer(1'b0, ADDR_COUNT, 32'h0);
        chk(rd, {16'h0000, c});
        xfer(1'b0, ADDR_STATUS, 32'h0);
        chk(rd & msk, st & msk);
    endtask

    initial begin
        for (int i = 0; i < 256; i++) begin
            u_mem.poke(32'h0000_1000 + 32'(i), 8'(i) & 8'h7F);
        end
        u_mem.poke(32'h0000_4000, 8'h00);
        u_mem.poke(32'h0000_4001, 8'h40);
        u_mem.poke(32'h0000_4002, 8'h80);
        u_mem.poke(32'h0000_2000, 8'h00);
        for (int i = 0; i < 4; i++) begin
            u_mem.poke(32'h0000_3000 + 32'(i), 8'h00);
        end
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int a = 0; a < 7; a++) begin
            xfer(1'b0, 8'(a * 4), 32'h0);
            chk(rd, 32'h0);
            chk({31'h0, err}, {31'h0, a == 6});
        end
        // two hits: zero result goes on, non-zero stops; slow memory
        u_mem.lat = 3;
        load(2'h0, INSN_DN, 32'h0000_4002, 32'h0000_1000, 16'h0003);
        go(2'h0);
        xfer(1'b1, ADDR_STR_PTR, 32'h0000_7777);
        wait_idle();
        expect_end(32'h0000_4000, 16'h0001, stat(8'h40, 0, 0, 0), '1);
        xfer(1'b0, ADDR_TBL_BASE, 32'h0);
        chk(rd, 32'h0000_1000);
        u_mem.lat = 0;
        load(2'h0, INSN_DN, 32'h0000_3001, 32'h0000_2000, 16'h0001);
        go(2'h0);
        wait_idle();
        expect_end(32'h0000_3000, 16'h0000, stat(8'h00, 0, 1, 1), '1);
        load(2'h0, 32'hFFFF_B862, 32'h0000_3000, 32'h0000_2000, 16'h0001);
        go(2'h0);
        wait_idle();
        expect_end(32'h0000_3001, 16'h0000, stat(8'h00, 0, 1, 1), '1);
        for (int i = 0; i < 3; i++) begin
            u_mem.lat = i;
            u_mem.poke(PTR[i], TGT[i]);
            u_mem.poke(TADR[i], 8'h5A + 8'(i));
            load(2'(i), 32'h0000_B862, PTR[i], BASE[i], 16'h0005);
            go(2'(i));
            wait_idle();
            expect_end(NPTR[i], 16'h0004, stat(8'h5A + 8'(i), 0, 0, 0), '1);
        end
        u_mem.lat = 0;
        // count 0 stands for 65536; a pending interrupt stops it after one step
        load(2'h2, INSN_DN, 32'h0000_3003, 32'h0000_2000, 16'h0000);
        irq_pending <= 1'b1;
        go(2'h2);
        wait_idle();
        expect_end(32'h0000_3002, 16'hFFFF, stat(8'h00, 1, 0, 1), '1);
        irq_pending <= 1'b0;
        xfer(1'b1, ADDR_COUNT, 32'h0000_0002);
        go(2'h2);
        wait_idle();
        expect_end(32'h0000_3000, 16'h0000, stat(8'h00, 0, 1, 1), '1);
        for (int i = 0; i < 8; i++) begin
            load((i == 7) ? 2'h3 : 2'h0, (i == 7) ? INSN_DN : BAD[i % 7],
                32'h0000_3003, 32'h0000_2000, 16'h0002);
            go((i == 7) ? 2'h3 : 2'h0);
            wait_idle();
            chk({31'h0, rd[ST_BADOP_BIT]}, 32'h1);
            xfer(1'b0, ADDR_STR_PTR, 32'h0);
            chk(rd, 32'h0000_3003);
        end
        results();
    end
endmodule // string_translate_test_unit_tb

// >>> tb/stt_mem_model.sv
module stt_mem_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire stt_pkg::stt_mem_req_t mem_i,
    output logic mem_ack_o,
    output logic [7:0] mem_rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import stt_pkg::*;

    logic [7:0] mem [logic [31:0]];
    int lat = 0;
    int wait_cnt = 0;

    initial begin
        mem_ack_o = 1'b0;
        mem_rdata_o = 8'h00;
    end

    // unwritten bytes read as the inverted low address byte, so a wrong address shows
    always @(posedge clk_i) begin
        if (rst_i) begin
            mem_ack_o <= 1'b0;
            mem_rdata_o <= 8'hA5;
            wait_cnt <= 0;
        end else if (mem_i.req && !mem_ack_o && wait_cnt >= lat) begin
            mem_ack_o <= 1'b1;
            mem_rdata_o <= mem.exists(mem_i.addr) ? mem[mem_i.addr] : ~mem_i.addr[7:0];
            wait_cnt <= 0;
        end else begin
            mem_ack_o <= 1'b0;
            // data is only valid with ack; toggle so a late sample is caught
            mem_rdata_o <= ~mem_rdata_o;
            if (mem_i.req && !mem_ack_o) begin
                wait_cnt <= wait_cnt + 1;
            end
        end
    end

    task poke(input logic [31:0] a, input logic [7:0] d);
        mem[a] = d;
    endtask
endmodule // stt_mem_model
